// ### common/pfs_pkg.sv
package pfs_pkg;

  localparam int PFS_NUM_REGS  = 4;
  localparam int PFS_NUM_PINS  = 28;
  localparam int PFS_NUM_SLOTS = 5;
  localparam int PFS_SEL_W     = 4;

  // register byte offsets
  localparam logic [11:0] PFS_SEL0_OFFSET = 12'h000;
  localparam logic [11:0] PFS_SEL1_OFFSET = 12'h004;
  localparam logic [11:0] PFS_SEL2_OFFSET = 12'h008;
  localparam logic [11:0] PFS_SEL3_OFFSET = 12'h00C;
  localparam logic [31:0] PFS_SEL_RESET   = 32'h0000_0000;

  localparam logic [1:0] PFS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PFS_RESP_SLVERR = 2'b10;

  // per-pin candidate functions, one slot per select code 0h, 1h, 2h, 4h, 8h
  typedef struct packed {
    logic [PFS_NUM_SLOTS-1:0] dout;
    logic [PFS_NUM_SLOTS-1:0] oe;
  } pfs_fn_t;

  // pad drive, output enable active low
  typedef struct packed {
    logic dout;
    logic oen;
  } pfs_pad_t;

  typedef enum logic [0:0] {
    PFS_WR_COLLECT = 1'b0,
    PFS_WR_RESP    = 1'b1
  } pfs_wr_state_t;

  typedef enum logic [0:0] {
    PFS_RD_IDLE = 1'b0,
    PFS_RD_RESP = 1'b1
  } pfs_rd_state_t;

  // bit position of each pin's select field across the four registers, pin 27 first
  localparam logic [PFS_NUM_PINS-1:0][6:0] PFS_SEL_POS = {
    7'd108, 7'd112, 7'd116, 7'd120, 7'd124,
    7'd64, 7'd68, 7'd72, 7'd76, 7'd80, 7'd84, 7'd88, 7'd92,
    7'd32, 7'd36, 7'd40, 7'd44, 7'd48, 7'd52, 7'd56, 7'd60,
    7'd0, 7'd4, 7'd8, 7'd12, 7'd16, 7'd20, 7'd24
  };

  // codes that name a function, pin 27 first
  localparam logic [PFS_NUM_PINS-1:0][15:0] PFS_VALID_MASK = {
    16'h0017, 16'h0017, 16'h0017, 16'h0016, 16'h0016,                       // R13 R14 R15
    16'h0117, 16'h0017, 16'h0017, 16'h0017, 16'h0017, 16'h0017, 16'h0017, 16'h0017, // R9 R10 R11 R12
    16'h0117, 16'h0107, 16'h0107, 16'h0107, 16'h0107, 16'h0107, 16'h0107, 16'h0117, // R6 R7 R8
    16'h0113, 16'h0113, 16'h0103, 16'h0103, 16'h0117, 16'h0117, 16'h0117    // R1 R2 R3 R4 R5
  };

  // codes whose function may drive the pad (output or bidirectional), pin 27 first
  localparam logic [PFS_NUM_PINS-1:0][15:0] PFS_DRIVE_MASK = {
    16'h0016, 16'h0012, 16'h0016, 16'h0012, 16'h0016,                       // R13 R14 R15
    16'h0112, 16'h0016, 16'h0016, 16'h0016, 16'h0016, 16'h0012, 16'h0016, 16'h0016, // R9 R10 R11 R12
    16'h0112, 16'h0106, 16'h0106, 16'h0106, 16'h0106, 16'h0102, 16'h0106, 16'h0112, // R6 R7 R8
    16'h0112, 16'h0112, 16'h0102, 16'h0102, 16'h0116, 16'h0102, 16'h0116    // R1 R2 R3 R4 R5
  };

  // select code to slot index
  function automatic logic [2:0] pfs_slot(input logic [PFS_SEL_W-1:0] code);
    logic [2:0] s;
    s = 3'd0;
    case (code)
      4'h1:    s = 3'd1;
      4'h2:    s = 3'd2;
      4'h4:    s = 3'd3;
      4'h8:    s = 3'd4;
      default: s = 3'd0;
    endcase
    return s;
  endfunction

endpackage

// ### hw/pfs_pin_cell.sv
module pfs_pin_cell
  import pfs_pkg::*;
#(
  parameter logic [15:0] VALID_MASK = 16'h0000,
  parameter logic [15:0] DRIVE_MASK = 16'h0000
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic [pfs_pkg::PFS_SEL_W-1:0] sel_i,
  input  wire pfs_pkg::pfs_fn_t           fn_i,
  output pfs_pkg::pfs_pad_t               pad_o
);

  logic [2:0] slot;
  logic       drive;
  pfs_pad_t   pad_nxt;

  // peripheral mode is never checked, only the selected slot's request is honoured
  assign slot  = pfs_slot(sel_i);                                        // R19
  // reserved and input-only codes leave the pad released
  assign drive = VALID_MASK[sel_i] & DRIVE_MASK[sel_i] & fn_i.oe[slot]; // R16
  assign pad_nxt.dout = drive & fn_i.dout[slot];
  assign pad_nxt.oen  = ~drive;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_o <= '{dout: 1'b0, oen: 1'b1};
    end else begin
      pad_o <= pad_nxt;                                                  // R20
    end
  end

endmodule // pfs_pin_cell

// ### hw/pfs_pin_select.sv
// Overview of operation
// R1: first register bits 27-24 route core input 16, mute, core output 16, uart2_request_to_send, gpio0.9
// R2: first register bits 23-20: core input 17, hi-rate tx clock, usb ref, uart1_clear_to_send, gpio0.10
// R3: reg0 bits 19-16: core in 18, hi-rate rx clock, core out 18, uart1_request_to_send, gpio0.11
// R4: first register bits 15-12 and 11-8 route core inputs, audio frame syncs, gpio0.12/13
// R5: first register bits 7-4 and 3-0 route core inputs, audio bit clocks, core outputs, gpio0.14/15
// R6: second register bits 31-28 route core input 8, serializer 8, serport1 clock, capture1, gpio0.0
// R7: second register middle six fields: tristate, serializers 9-14, serport1 signals, gpio0.1-6
// R8: second register bits 3-0: tristate, serializer 15, pwm0 trip, capture2, gpio0.7
// R9: third register bits 31-28: serport0 clock, serializer 0, capture0, gpio8.7; 5h-Fh undefined
// R10: third register bits 27-8: tristate, serializers 1-5, serport0 signals, gpio1.9-13
// R11: third register bits 7-4: core input 6, serializer 6, serport0 rx clock, gpio1.14
// R12: third register bits 3-0: core input 7, serializer 7, pwm1 trip, core out 17, gpio1.15
// R13: fourth register bits 31-24: 0 reserved, spi0 selects 2/3, uart0_request_to_send/cts, gpio8.1/2
// R14: fourth register bits 23-16: tristate, spi0 selects 4/5, uart0_transmit_data/rxd, gpio8.3/4
// R15: fourth register bits 15-12: tristate, spi0_slave_in_master_out, pwm sync out, gpio8.5
// R16: software avoids reserved codes since the pin behaviour is then undefined
// R17: every select field is read/write and clears to zero on reset
// R18: selects steer only output data and enable; pad input reaches all peripherals
// R19: the mux never checks that a peripheral's mode matches its selected pin
// R20: a register write changes pad routing from the following cycle; here the register changes then and the registered pads_o one cycle later
//
// Chosen here: the AXI4-Lite register port and the register offsets.
module pfs_pin_select
  import pfs_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                                    clk_i,
  input  wire logic                                    nrst_i,
  input  wire logic [ADDR_W-1:0]                       s_axi_awaddr_i,
  input  wire logic                                    s_axi_awvalid_i,
  output logic                                         s_axi_awready_o,
  input  wire logic [31:0]                             s_axi_wdata_i,
  input  wire logic [3:0]                              s_axi_wstrb_i,
  input  wire logic                                    s_axi_wvalid_i,
  output logic                                         s_axi_wready_o,
  output logic [1:0]                                   s_axi_bresp_o,
  output logic                                         s_axi_bvalid_o,
  input  wire logic                                    s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]                       s_axi_araddr_i,
  input  wire logic                                    s_axi_arvalid_i,
  output logic                                         s_axi_arready_o,
  output logic [31:0]                                  s_axi_rdata_o,
  output logic [1:0]                                   s_axi_rresp_o,
  output logic                                         s_axi_rvalid_o,
  input  wire logic                                    s_axi_rready_i,
  input  wire pfs_pkg::pfs_fn_t [pfs_pkg::PFS_NUM_PINS-1:0] fn_i,
  output pfs_pkg::pfs_pad_t [pfs_pkg::PFS_NUM_PINS-1:0]     pads_o,
  input  wire logic [pfs_pkg::PFS_NUM_PINS-1:0]        pad_din_i,
  output logic [pfs_pkg::PFS_NUM_PINS-1:0]             pin_din_o
);

  import pfs_pkg::*;

  if (ADDR_W < 4) begin : g_addr_check
    $error("ADDR_W too narrow for four word registers");
  end

  typedef struct packed {
    logic       hit;
    logic [1:0] idx;
  } pfs_dec_t;

  // word decode of a byte address, shared by both directions
  function automatic pfs_dec_t pfs_decode(input logic [ADDR_W-1:0] addr);
    pfs_dec_t d;
    d.idx = addr[3:2];
    d.hit = (addr[ADDR_W-1:4] == '0) && (addr[1:0] == 2'b00);
    return d;
  endfunction

  logic                            rst_meta_r;
  logic                            rst_n;
  logic [PFS_NUM_PINS-1:0]         din_meta_r;
  pfs_wr_state_t                   wr_state_r;
  pfs_rd_state_t                   rd_state_r;
  logic                            awready_r;
  logic                            wready_r;
  logic                            bvalid_r;
  logic [1:0]                      bresp_r;
  logic                            arready_r;
  logic                            rvalid_r;
  logic [1:0]                      rresp_r;
  logic [31:0]                     rdata_r;
  logic [ADDR_W-1:0]               awaddr_r;
  logic [31:0]                     wdata_r;
  logic [3:0]                      wstrb_r;
  logic [PFS_NUM_REGS-1:0][31:0]   regs_r;
  logic [PFS_NUM_REGS-1:0][31:0]   regs_nxt;
  logic [4*PFS_NUM_REGS*8-1:0]     regs_flat;
  logic [PFS_NUM_PINS-1:0][3:0]    sel_w;
  logic [31:0]                     wmask;
  pfs_dec_t                        wr_dec;
  pfs_dec_t                        rd_dec;
  logic                            aw_fire;
  logic                            w_fire;
  logic                            ar_fire;
  logic                            wr_go;
  logic                            wr_en;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // pad inputs broadcast to every sharing peripheral whatever the selects say
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      din_meta_r <= '0;
      pin_din_o  <= '0;
    end else begin
      din_meta_r <= pad_din_i;
      pin_din_o  <= din_meta_r;                                          // R18
    end
  end

  // bus handshakes and decode
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o  = wready_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rresp_o   = rresp_r;
  assign s_axi_rdata_o   = rdata_r;

  assign aw_fire = s_axi_awvalid_i & awready_r;
  assign w_fire  = s_axi_wvalid_i & wready_r;
  assign ar_fire = s_axi_arvalid_i & arready_r;
  assign wr_dec  = pfs_decode(awaddr_r);
  assign rd_dec  = pfs_decode(s_axi_araddr_i);
  assign wr_go   = (wr_state_r == PFS_WR_COLLECT) & ~awready_r & ~wready_r;
  assign wr_en   = wr_go & wr_dec.hit;
  assign wmask   = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // write channel: take address and data in either order, then answer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_state_r <= PFS_WR_COLLECT;
      awready_r  <= 1'b1;
      wready_r   <= 1'b1;
      bvalid_r   <= 1'b0;
      bresp_r    <= PFS_RESP_OKAY;
      awaddr_r   <= '0;
      wdata_r    <= 32'h0000_0000;
      wstrb_r    <= 4'h0;
    end else begin
      case (wr_state_r)
        PFS_WR_COLLECT: begin
          if (aw_fire) begin
            awaddr_r  <= s_axi_awaddr_i;
            awready_r <= 1'b0;
          end
          if (w_fire) begin
            wdata_r  <= s_axi_wdata_i;
            wstrb_r  <= s_axi_wstrb_i;
            wready_r <= 1'b0;
          end
          if (wr_go) begin
            bvalid_r   <= 1'b1;
            bresp_r    <= wr_dec.hit ? PFS_RESP_OKAY : PFS_RESP_SLVERR;
            wr_state_r <= PFS_WR_RESP;
          end
        end
        PFS_WR_RESP: begin
          if (s_axi_bready_i) begin
            bvalid_r   <= 1'b0;
            awready_r  <= 1'b1;
            wready_r   <= 1'b1;
            wr_state_r <= PFS_WR_COLLECT;
          end
        end
        default: begin
          wr_state_r <= PFS_WR_COLLECT;
        end
      endcase
    end
  end

  // select registers with byte strobes
  for (genvar r = 0; r < PFS_NUM_REGS; r++) begin : g_reg
    assign regs_nxt[r] = (wr_en && (wr_dec.idx == 2'(r))) ?
                         ((regs_r[r] & ~wmask) | (wdata_r & wmask)) : regs_r[r];
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      regs_r <= {PFS_NUM_REGS{PFS_SEL_RESET}};                           // R17
    end else begin
      regs_r <= regs_nxt;                                                // R17
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_r <= PFS_RD_IDLE;
      arready_r  <= 1'b1;
      rvalid_r   <= 1'b0;
      rresp_r    <= PFS_RESP_OKAY;
      rdata_r    <= 32'h0000_0000;
    end else begin
      case (rd_state_r)
        PFS_RD_IDLE: begin
          if (ar_fire) begin
            arready_r  <= 1'b0;
            rvalid_r   <= 1'b1;
            rdata_r    <= rd_dec.hit ? regs_r[rd_dec.idx] : 32'h0000_0000; // R17
            rresp_r    <= rd_dec.hit ? PFS_RESP_OKAY : PFS_RESP_SLVERR;
            rd_state_r <= PFS_RD_RESP;
          end
        end
        PFS_RD_RESP: begin
          if (s_axi_rready_i) begin
            rvalid_r   <= 1'b0;
            arready_r  <= 1'b1;
            rd_state_r <= PFS_RD_IDLE;
          end
        end
        default: begin
          rd_state_r <= PFS_RD_IDLE;
        end
      endcase
    end
  end

  // per-pin output mux
  assign regs_flat = regs_r;

  for (genvar p = 0; p < PFS_NUM_PINS; p++) begin : g_pin
    assign sel_w[p] = regs_flat[PFS_SEL_POS[p] +: PFS_SEL_W];
    pfs_pin_cell #(
      .VALID_MASK (PFS_VALID_MASK[p]),                                   // R8 R10 R11 R14 R15
      .DRIVE_MASK (PFS_DRIVE_MASK[p])
    ) u_cell (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .sel_i   (sel_w[p]),                                               // R3
      .fn_i    (fn_i[p]),                                                // R4
      .pad_o   (pads_o[p])                                               // R5
    );
  end

  // checks on routing and register behaviour
  logic wr_seen_r;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_seen_r <= 1'b0;
    end else begin
      wr_seen_r <= wr_en;
    end
  end

  property p_r1_uart2_request_to_send;
    @(posedge clk_i) disable iff (!rst_n)
    (sel_w[0] == 4'h4) |=>
      (pads_o[0].oen == !$past(fn_i[0].oe[3])) && (pads_o[0].dout == $past(fn_i[0].dout[3] & fn_i[0].oe[3]));
  endproperty
  a_r1_uart2_request_to_send: assert property (p_r1_uart2_request_to_send) else $error("pin 0 code 4h not routed"); // R1

  property p_r2_input_only;
    @(posedge clk_i) disable iff (!rst_n)
    (sel_w[1] == 4'h2) ##1 (sel_w[1] == 4'h2) |-> pads_o[1].oen && !pads_o[1].dout;
  endproperty
  a_r2_input_only: assert property (p_r2_input_only) else $error("usb ref clock pin driven"); // R2

  property p_r6_capture1;
    @(posedge clk_i) disable iff (!rst_n)
    (sel_w[7] == 4'h4) |=> pads_o[7].oen == !$past(fn_i[7].oe[3]);
  endproperty
  a_r6_capture1: assert property (p_r6_capture1) else $error("capture1 enable not routed"); // R6

  property p_r7_tristate;
    @(posedge clk_i) disable iff (!rst_n)
    (sel_w[8] == 4'h0) |=> pads_o[8].oen && !pads_o[8].dout;
  endproperty
  a_r7_tristate: assert property (p_r7_tristate) else $error("pin 8 not released at code 0"); // R7

  property p_r9_undefined;
    @(posedge clk_i) disable iff (!rst_n)
    (sel_w[15] >= 4'h5) |=> pads_o[15].oen;
  endproperty
  a_r9_undefined: assert property (p_r9_undefined) else $error("undefined code drives pin 15"); // R9

  property p_r12_gpio;
    @(posedge clk_i) disable iff (!rst_n)
    (sel_w[22] == 4'h8) |=> pads_o[22].dout == $past(fn_i[22].dout[4] & fn_i[22].oe[4]);
  endproperty
  a_r12_gpio: assert property (p_r12_gpio) else $error("gpio1.15 data not routed"); // R12

  property p_r13_reserved;
    @(posedge clk_i) disable iff (!rst_n)
    (sel_w[23] == 4'h0) |=> pads_o[23].oen;
  endproperty
  a_r13_reserved: assert property (p_r13_reserved) else $error("reserved code drives pin 23"); // R13

  property p_r17_reset_clear;
    @(posedge clk_i) disable iff (!rst_n)
    $rose(rst_n) |-> (regs_r == '0) && pads_o[8].oen;
  endproperty
  a_r17_reset_clear: assert property (p_r17_reset_clear) else $error("registers not clear after reset"); // R17

  property p_r18_input_path;
    @(posedge clk_i) disable iff (!rst_n)
    $past(rst_n, 2) |-> pin_din_o == $past(pad_din_i, 2);
  endproperty
  a_r18_input_path: assert property (p_r18_input_path) else $error("pad input not passed through"); // R18

  property p_r20_write_update;
    @(posedge clk_i) disable iff (!rst_n)
    (wr_en && (wr_dec.idx == 2'd1) && (wstrb_r == 4'hF)) |=>
      (regs_r[1] == $past(wdata_r)) && wr_seen_r && bvalid_r;
  endproperty
  a_r20_write_update: assert property (p_r20_write_update) else $error("write not applied next cycle"); // R20

endmodule // pfs_pin_select

// ### verification/pfs_periph_model.sv
module pfs_periph_model
  import pfs_pkg::*;
(
  input  wire logic                                    lvl_i,
  input  wire logic [pfs_pkg::PFS_NUM_PINS-1:0]        oe_en_i,
  output pfs_pkg::pfs_fn_t [pfs_pkg::PFS_NUM_PINS-1:0] fn_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pfs_pkg::*;

  // every function of a pin drives at once while that pin's oe_en_i bit is set, whatever its mode
  always_comb begin
    for (int p = 0; p < PFS_NUM_PINS; p++) begin
      for (int s = 0; s < PFS_NUM_SLOTS; s++) begin
        fn_o[p].dout[s] = lvl_i ^ p[0] ^ s[0];
        fn_o[p].oe[s]   = oe_en_i[p];
      end
    end
  end
endmodule // pfs_periph_model

// ### verification/pfs_pin_select_test.sv
module pfs_pin_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pfs_pkg::*;

  // pin, code, expected drive
  localparam logic [15:0] CASES [32] = '{
    16'h0011, 16'h0021, 16'h0030, 16'h0120, 16'h0140, 16'h0241, 16'h0311, 16'h0411,
    16'h0541, 16'h0641, 16'h0720, 16'h0741, 16'h0800, 16'h0821, 16'h0920, 16'h0E20,
    16'h0E41, 16'h0F00, 16'h0F50, 16'h1021, 16'h1120, 16'h1521, 16'h1620, 16'h1641,
    16'h1700, 16'h1721, 16'h1820, 16'h1921, 16'h1A20, 16'h1B21, 16'h1B11, 16'h0041
  };

  logic                         clk       = 1'b0;
  logic                         nrst      = 1'b0;
  logic [11:0]                  awaddr    = '0;
  logic [11:0]                  araddr    = '0;
  logic [31:0]                  wdata     = '0;
  logic [3:0]                   wstrb     = '0;
  logic                         awvalid   = 1'b0;
  logic                         wvalid    = 1'b0;
  logic                         bready    = 1'b0;
  logic                         arvalid   = 1'b0;
  logic                         rready    = 1'b0;
  logic                         lvl       = 1'b0;
  logic [PFS_NUM_PINS-1:0]      oe_en     = '1;
  logic [PFS_NUM_PINS-1:0]      pad_din   = '0;
  logic [3:0]                   codes [PFS_NUM_PINS] = '{default: 4'h0};
  logic                         awready;
  logic                         wready;
  logic                         bvalid;
  logic                         arready;
  logic                         rvalid;
  logic [1:0]                   bresp;
  logic [1:0]                   rresp;
  logic [31:0]                  rdata;
  logic [PFS_NUM_PINS-1:0]      pin_din;
  pfs_fn_t [PFS_NUM_PINS-1:0]   fn;
  pfs_pad_t [PFS_NUM_PINS-1:0]  pads;
  int                           n_fail    = 0;
  int                           cmp_count = 0;

  always #2 clk = ~clk;

  pfs_periph_model pfs_periph_model_inst (.lvl_i(lvl), .oe_en_i(oe_en), .fn_o(fn));

  pfs_pin_select pfs_pin_select_inst (
    .clk_i(clk), .nrst_i(nrst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .fn_i(fn), .pads_o(pads), .pad_din_i(pad_din), .pin_din_o(pin_din)
  );

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic hung();
    n_fail++;
    $display("wait timed out at %0t", $time);
    give_verdict();
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (aw_ok && w_ok && bvalid === 1'b1) break;
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    if (n == 64) hung();
    chk_val(bresp, er);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic took;
    took = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (took && rvalid === 1'b1) break;
      if (arvalid && arready === 1'b1) begin
        took = 1'b1;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
    if (n == 64) hung();
    chk_val(rdata, ed);
    chk_val(rresp, er);
  endtask

  // packs the per-pin codes into the four select words
  task automatic load_codes();
    logic [31:0] w [4];
    int r;
    int pos;
    w = '{default: 32'h0000_0000};
    for (int p = 0; p < PFS_NUM_PINS; p++) begin
      r = (p < 7) ? 0 : (p < 15) ? 1 : (p < 23) ? 2 : 3;
      pos = (r == 0) ? 24 - 4 * p : 28 - 4 * (p - ((r == 1) ? 7 : (r == 2) ? 15 : 23));
      w[r][pos+:4] = codes[p];
    end
    for (int i = 0; i < 4; i++) wr_chk(12'(4 * i), w[i], 4'hF, PFS_RESP_OKAY);
  endtask

  task automatic chk_pads(input logic [PFS_NUM_PINS-1:0] drv);
    logic odd;
    for (int p = 0; p < PFS_NUM_PINS; p++) begin
      odd = (codes[p] == 4'h1) || (codes[p] == 4'h4);
      if (drv[p] && oe_en[p]) chk_val(pads[p], {lvl ^ p[0] ^ odd, 1'b0});
      else chk_val(pads[p], 2'b01);
    end
  endtask

  initial begin
    do_reset();
    for (int i = 0; i < 4; i++) rd_chk(12'(4 * i), PFS_SEL_RESET, PFS_RESP_OKAY);
    #1;
    chk_pads('0);
    $display("test reset state done");
    for (int i = 0; i < 4; i++) wr_chk(12'(4 * i), 32'hA5C3_1E96, 4'hF, PFS_RESP_OKAY);
    for (int i = 0; i < 4; i++) rd_chk(12'(4 * i), 32'hA5C3_1E96, PFS_RESP_OKAY);
    wr_chk(PFS_SEL1_OFFSET, 32'h0000_0000, 4'hF, PFS_RESP_OKAY);
    wr_chk(PFS_SEL1_OFFSET, 32'hFFFF_FFFF, 4'h2, PFS_RESP_OKAY);
    rd_chk(PFS_SEL1_OFFSET, 32'h0000_FF00, PFS_RESP_OKAY);
    rd_chk(12'h010, 32'h0000_0000, PFS_RESP_SLVERR);
    rd_chk(12'h002, 32'h0000_0000, PFS_RESP_SLVERR);
    wr_chk(12'h00E, 32'h0000_0000, 4'hF, PFS_RESP_SLVERR);
    rd_chk(PFS_SEL3_OFFSET, 32'hA5C3_1E96, PFS_RESP_OKAY);
    do_reset();
    for (int i = 0; i < 4; i++) rd_chk(12'(4 * i), PFS_SEL_RESET, PFS_RESP_OKAY);
    $display("test registers done");
    for (int p = 0; p < PFS_NUM_PINS; p++) codes[p] = (p < 15 || p == 22) ? 4'h8 : 4'h4;
    load_codes();
    #1;
    chk_pads('1);
    @(posedge clk);
    lvl <= 1'b1;
    oe_en[3] <= 1'b0;
    pad_din <= 28'h5A5_C3E9;
    settle();
    chk_pads('1);
    chk_val(pin_din, 28'h5A5_C3E9);
    @(posedge clk);
    oe_en <= '1;
    $display("test gpio routing done");
    for (int i = 0; i < 32; i++) begin
      codes = '{default: 4'h0};
      codes[CASES[i][15:8]] = CASES[i][7:4];
      load_codes();
      #1;
      chk_pads(28'(CASES[i][0]) << CASES[i][15:8]);
    end
    @(posedge clk);
    pad_din <= 28'hA5A_3C16;
    settle();
    chk_val(pin_din, 28'hA5A_3C16);
    $display("test function codes done");
    give_verdict();
  end
endmodule // pfs_pin_select_test
